// *** logic/epi_pkg.sv ***
/*
  package for the external pin interrupt unit: register offsets, field layout,
  reset values, sense modes and timing constants.
  assumes a 32-bit avalon-mm slave port with word-aligned byte addresses.
*/
package epi_pkg;
  localparam int unsigned NCH = 3;
  localparam logic [4:0] OFF_SENSE = 5'h00;
  localparam logic [4:0] OFF_MASK = 5'h04;
  localparam logic [4:0] OFF_FLAGS = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] PIN_RST = 3'h7;
  localparam logic WAIT_RST = 1'b1;
  localparam logic [15:0] SCNT_RST = 16'h0000;
  localparam logic [1:0] WAKE_SAMPLES = 2'h2;
  localparam logic [15:0] STARTUP_CYCLES_DEF = 16'h0040;
  localparam int unsigned CTRL_GIE_BIT = 0;
  localparam int unsigned CTRL_PDOWN_BIT = 1;

  typedef enum logic [1:0]
  {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } epi_sense_e;

  typedef enum logic [1:0]
  {
    WK_RUN = 2'b00,
    WK_DOWN = 2'b01,
    WK_START = 2'b10
  } epi_wake_e;

  typedef struct packed
  {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } epi_req_s;
endpackage

// *** logic/epi_unit.sv ***
/*
  external pin interrupt unit: three channels, sense selection, mask, flags,
  vector-entry acknowledge and power-down level wake-up.
  assumes pins synchronous to core_clk_i and a slow watchdog tick input.
*/
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
module epi_unit
#(
  parameter logic [15:0] STARTUP_CYCLES = epi_pkg::STARTUP_CYCLES_DEF
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [2:0] external_request_pins_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic wdt_tick_i,
  output logic [2:0] request_o,
  output logic irq_o,
  output logic wake_o
);
  // bus request as one carrier
  epi_pkg::epi_req_s req;
  logic access;
  logic commit_wr;

  // register bank
  logic [7:0] sense_q;
  logic [7:0] sense_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ack_q;
  logic ack_d;
  logic wait_q;
  logic wait_d;

  // pin sampling
  logic [2:0] pin_q;
  logic [2:0] pin_d;
  logic [2:0] prev_q;
  logic [2:0] prev_d;

  // flags and requests
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [2:0] req_q;
  logic [2:0] req_d;
  logic irq_q;
  logic irq_d;

  // wake sequencer
  epi_pkg::epi_wake_e wst_q;
  epi_pkg::epi_wake_e wst_d;
  logic [1:0] wcnt_q;
  logic [1:0] wcnt_d;
  logic [15:0] scnt_q;
  logic [15:0] scnt_d;
  logic wake_q;
  logic wake_d;

  // per-channel decode results
  logic [2:0] edge_hit;
  logic [2:0] level_act;
  logic [2:0] low_mode;
  logic [2:0] flags_vis;
  logic [2:0] w1c;
  logic pdown;
  logic gie;

  assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                 writedata: avs_writedata_i};
  // taken while no answer is pending; a write lands at the answer edge
  assign access = (req.read | req.write) & ~ack_q;
  assign commit_wr = req.write & ack_q;
  assign pdown = ctrl_q[epi_pkg::CTRL_PDOWN_BIT];
  assign gie = ctrl_q[epi_pkg::CTRL_GIE_BIT];
  assign w1c = (commit_wr && req.address == epi_pkg::OFF_FLAGS) ? req.writedata[2:0] : 3'h0;

  // per-channel sense decode
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ch
      logic [1:0] sel;
      logic hit;
      assign sel = sense_q[2*gi+1:2*gi];
      assign low_mode[gi] = (sel == epi_pkg::SENSE_LOW);
      // level is taken from the sampled pin_q, not from the pad
      assign level_act[gi] = low_mode[gi] & ~pin_q[gi];
      always_comb
      begin
        case (epi_pkg::epi_sense_e'(sel))
          epi_pkg::SENSE_ANY:
          begin
            hit = pin_q[gi] ^ prev_q[gi];
          end
          epi_pkg::SENSE_FALL:
          begin
            hit = prev_q[gi] & ~pin_q[gi];
          end
          epi_pkg::SENSE_RISE:
          begin
            hit = ~prev_q[gi] & pin_q[gi];
          end
          default:
          begin
            hit = 1'b0;
          end
        endcase
      end
      // edges only count while the core clock runs
      assign edge_hit[gi] = hit & ~pdown;
      assign flags_vis[gi] = low_mode[gi] ? 1'b0 : flags_q[gi];
    end
  endgenerate

  // register bank next state
  always_comb
  begin
    sense_d = sense_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    rdata_d = 32'h0;
    ack_d = access;
    if (commit_wr)
    begin
      case (req.address)
        epi_pkg::OFF_SENSE:
        begin
          sense_d = req.writedata[7:0];
        end
        epi_pkg::OFF_MASK:
        begin
          mask_d = req.writedata[2:0];
        end
        epi_pkg::OFF_CTRL:
        begin
          ctrl_d = req.writedata[1:0];
        end
        default:
        begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    if (access && req.read)
    begin
      case (req.address)
        epi_pkg::OFF_SENSE:
        begin
          rdata_d = {24'h0, sense_q};
        end
        epi_pkg::OFF_MASK:
        begin
          rdata_d = {29'h0, mask_q};
        end
        epi_pkg::OFF_FLAGS:
        begin
          rdata_d = {29'h0, flags_vis};
        end
        epi_pkg::OFF_CTRL:
        begin
          rdata_d = {30'h0, ctrl_q};
        end
        epi_pkg::OFF_STATUS:
        begin
          rdata_d = {29'h0, pin_q};
        end
        default:
        begin
          rdata_d = 32'h0;
        end
      endcase
    end
    // completed wake hands the clock back
    if (wake_d)
    begin
      ctrl_d[epi_pkg::CTRL_PDOWN_BIT] = 1'b0;
    end
    wait_d = ~ack_d;
  end

  // sampling stage ahead of edge detection; level wake also sees this sampled pin_q
  always_comb
  begin
    pin_d = external_request_pins_i;
    prev_d = pin_q;
  end

  // flags and requests next state
  always_comb
  begin
    flags_d = flags_q & ~vector_ack_i;
    flags_d = flags_d & ~w1c;
    // a new event wins over acknowledge and clear in the same cycle
    flags_d = flags_d | edge_hit;
    flags_d = flags_d & ~low_mode;
    // nothing is requested until the core is awake
    req_d = pdown ? 3'h0 : ((flags_d | level_act) & mask_q);
    irq_d = gie & (|req_d);
  end

  // power-down wake sequencer
  always_comb
  begin
    wst_d = wst_q;
    wcnt_d = wcnt_q;
    scnt_d = scnt_q;
    wake_d = 1'b0;
    case (wst_q)
      epi_pkg::WK_RUN:
      begin
        wcnt_d = 2'h0;
        if (pdown)
        begin
          wst_d = epi_pkg::WK_DOWN;
        end
      end
      epi_pkg::WK_DOWN:
      begin
        if (!pdown)
        begin
          wst_d = epi_pkg::WK_RUN;
        end
        else if (wdt_tick_i)
        begin
          if (|(level_act & mask_q))
          begin
            wcnt_d = wcnt_q + 2'h1;
            if (wcnt_q + 2'h1 >= epi_pkg::WAKE_SAMPLES)
            begin
              wst_d = epi_pkg::WK_START;
              scnt_d = STARTUP_CYCLES;
            end
          end
          else
          begin
            wcnt_d = 2'h0;
          end
        end
      end
      epi_pkg::WK_START:
      begin
        scnt_d = scnt_q - 16'h1;
        // wake finishes whatever the level does now
        if (scnt_q <= 16'h1)
        begin
          wake_d = 1'b1;
          wst_d = epi_pkg::WK_RUN;
        end
      end
      default:
      begin
        wst_d = epi_pkg::WK_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sense_q <= epi_pkg::SENSE_RST;
      mask_q <= epi_pkg::MASK_RST;
      ctrl_q <= epi_pkg::CTRL_RST;
      rdata_q <= 32'h0;
      ack_q <= 1'b0;
      wait_q <= epi_pkg::WAIT_RST;
    end
    else
    begin
      sense_q <= sense_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      wait_q <= wait_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_q <= epi_pkg::PIN_RST;
      prev_q <= epi_pkg::PIN_RST;
    end
    else
    begin
      pin_q <= pin_d;
      prev_q <= prev_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flags_q <= epi_pkg::FLAGS_RST;
      req_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      req_q <= req_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wst_q <= epi_pkg::WK_RUN;
      wcnt_q <= 2'h0;
      scnt_q <= epi_pkg::SCNT_RST;
      wake_q <= 1'b0;
    end
    else
    begin
      wst_q <= wst_d;
      wcnt_q <= wcnt_d;
      scnt_q <= scnt_d;
      wake_q <= wake_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign request_o = req_q;
  assign irq_o = irq_q;
  assign wake_o = wake_q;
endmodule

// *** dv/epi_monitor.sv ***
/* port assertions for epi_unit
   assumes a bind onto every epi_unit */
`timescale 1ns/1ns
module epi_monitor
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [2:0] external_request_pins_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic wdt_tick_i,
  input wire logic [2:0] request_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  logic [7:0] sn_q;
  logic [2:0] mk_q;
  logic pd_q;
  logic wa;
  logic [1:0] s0;
  logic p0;
  assign wa = !avs_waitrequest_o && avs_write_i;
  assign s0 = sn_q[1:0];
  assign p0 = external_request_pins_i[0];
  // shadow of sense and mask as software wrote them, and of power-down as written or cleared by wake
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      {sn_q, mk_q, pd_q} <= '0;
    else if (wa && avs_address_i == 5'h00)
      sn_q <= avs_writedata_i[7:0];
    else if (wa && avs_address_i == 5'h04)
      mk_q <= avs_writedata_i[2:0];
    else if (wa && avs_address_i == 5'h0c)
      pd_q <= avs_writedata_i[1];
    else if (wake_o)
      pd_q <= 1'h0;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_ANSWER: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  AST_ANSWER_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  AST_GATE: assert property ((|(request_o & ~mk_q & ~$past(mk_q))) == 1'h0)
    else $error("request on masked channel");
  AST_IRQ: assert property (irq_o |-> |request_o)
    else $error("irq without request");
  AST_RISE: assert property ($rose(p0) && s0 == 2'h3 && mk_q[0] && !pd_q |-> ##[1:3] request_o[0])
    else $error("rising edge missed");
  AST_FALL: assert property ($fell(p0) && s0 == 2'h2 && mk_q[0] && !pd_q |-> ##[1:3] request_o[0])
    else $error("falling edge missed");
  AST_ANY: assert property ($changed(p0) && s0 == 2'h1 && mk_q[0] && !pd_q |-> ##[1:3] request_o[0])
    else $error("change missed");
  AST_LEVEL: assert property ((!p0 && s0 == 2'h0 && mk_q[0] && !pd_q) [*3] |-> request_o[0])
    else $error("low level not requesting");
  AST_NO_LATCH: assert property ((p0 && s0 == 2'h0) [*3] |-> !request_o[0])
    else $error("level request latched");
  AST_WAKE: assert property ($rose(wake_o) |-> pd_q)
    else $error("wake outside power-down");
  AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  cover property (request_o[0] && irq_o);
  cover property (wake_o);
  cover property ($rose(request_o[2]));
endmodule
bind epi_unit epi_monitor u_mon (.*);

// *** dv/epi_src.sv ***
/* pin source model for the three request pins
   assumes the bench sets the wanted levels */
`timescale 1ns/1ns
module epi_src
(
  input wire logic clk_i,
  input wire logic [2:0] lvl_i,
  output logic [2:0] pins_o
);
  // levels change on edges only and are held whole cycles
  always_ff @(posedge clk_i)
    pins_o <= lvl_i;
endmodule

// *** dv/tb.sv ***
/* self-checking bench for epi_unit
   assumes epi_src drives the pins */
`timescale 1ns/1ns
module tb;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [4:0] avs_address_i = '0;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [2:0] external_request_pins_i;
  logic [2:0] vector_ack_i = '0;
  logic wdt_tick_i = 1'h0;
  logic [2:0] request_o;
  logic irq_o;
  logic wake_o;
  logic [2:0] lvl = 3'h7;
  logic [31:0] q;
  logic [7:0] r;
  logic e;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 32'h544087a8;
  epi_unit #(.STARTUP_CYCLES(16'h0004)) DUT (.*);
  epi_src u_src (.clk_i(core_clk_i), .lvl_i(lvl), .pins_o(external_request_pins_i));
  initial forever #4 core_clk_i = ~core_clk_i;
  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task acc(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  function logic expf(input logic [1:0] m, input logic rising);
    return m == 2'h1 || m == {1'h1, rising};
  endfunction
  always @(posedge core_clk_i)
    if (++cyc > 20000)
    begin
      failures++;
      report_and_stop;
    end
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    for (int a = 0; a < 24; a += 4)
      if (a != 16)
      begin
        acc(a[4:0], 1'h0, '0);
        chk("reset value", 32'h0, q);
      end
    r = $random(seed);
    acc(5'h00, 1'h1, {24'hffffff, r});
    acc(5'h00, 1'h0, '0);
    chk("sense", {24'h0, r}, q);
    acc(5'h04, 1'h1, 32'hffffffff);
    acc(5'h04, 1'h0, '0);
    chk("mask", 32'h7, q);
    acc(5'h0c, 1'h1, 32'h1);
    for (int c = 0; c < 3; c++)
      for (int m = 0; m < 4; m++)
      begin
        acc(5'h04, 1'h1, '0);
        acc(5'h00, 1'h1, 32'(m) << (2 * c));
        acc(5'h08, 1'h1, 32'h7);
        acc(5'h04, 1'h1, 32'h1 << c);
        lvl[c] <= 1'h0;
        repeat (4) @(posedge core_clk_i);
        e = m == 0 || expf(m[1:0], 1'h0);
        chk("req fall", e, request_o[c]);
        chk("irq", e, irq_o);
        acc(5'h08, 1'h0, '0);
        chk("flag fall", 32'(expf(m[1:0], 1'h0)) << c, q);
        acc(5'h08, 1'h1, 32'h7);
        acc(5'h08, 1'h0, '0);
        chk("flag w1c", 32'h0, q);
        lvl[c] <= 1'h1;
        repeat (4) @(posedge core_clk_i);
        chk("req rise", expf(m[1:0], 1'h1), request_o[c]);
        acc(5'h08, 1'h1, '0);
        acc(5'h08, 1'h0, '0);
        chk("flag rise", 32'(expf(m[1:0], 1'h1)) << c, q);
        vector_ack_i <= 3'h1 << c;
        @(posedge core_clk_i);
        vector_ack_i <= 3'h0;
        repeat (2) @(posedge core_clk_i);
        chk("ack", 32'h0, request_o[c]);
      end
    acc(5'h04, 1'h1, '0);
    acc(5'h00, 1'h1, '0);
    acc(5'h04, 1'h1, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      acc(5'h0c, 1'h1, 32'h2);
      lvl[0] <= 1'h0;
      repeat (3) @(posedge core_clk_i);
      repeat (2)
      begin
        @(posedge core_clk_i);
        wdt_tick_i <= 1'h1;
        @(posedge core_clk_i);
        wdt_tick_i <= 1'h0;
      end
      // second pass drops the level during start-up
      if (k == 1)
        lvl[0] <= 1'h1;
      for (int i = 0; i < 40 && wake_o !== 1'h1; i++) @(posedge core_clk_i);
      chk("wake", 32'h1, wake_o);
      repeat (4) @(posedge core_clk_i);
      chk("req after wake", 32'(k == 0), request_o[0]);
      chk("irq gie off", 32'h0, irq_o);
    end
    report_and_stop;
  end
endmodule
